// file: include/spi_port_pkg.sv
// constants, types and helpers shared by the byte-wide serial port
// assumes a single ref_clk domain; register offsets are word indices
package spi_port_pkg;

  // register bus
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 2'h2;

  // control register fields
  localparam int CTRL_IE = 7;
  localparam int CTRL_EN = 6;
  localparam int CTRL_ORDER = 5;
  localparam int CTRL_MSTR = 4;
  localparam int CTRL_CLOCK_POLARITY = 3;
  localparam int CTRL_CLOCK_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  // status register fields
  localparam int STAT_SPIF = 7;
  localparam int STAT_COLL = 6;
  localparam int STAT_DBL = 0;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // half-edge index of the last sck edge of a byte (16 edges)
  localparam logic [3:0] EDGE_LAST = 4'hF;

  // ref_clk cycles per sck half period, index {double, rate_hi, rate_lo}
  localparam int HALF_W = 7;

  typedef enum logic {ST_IDLE, ST_RUN} xfer_state_t;

  function automatic logic [HALF_W-1:0] half_period(input logic [2:0] sel);
    logic [HALF_W-1:0] h;
    h = 7'h01;
    unique case (sel)
      3'h0: h = 7'h02;
      3'h1: h = 7'h08;
      3'h2: h = 7'h20;
      3'h3: h = 7'h40;
      3'h4: h = 7'h01;
      3'h5: h = 7'h04;
      3'h6: h = 7'h10;
      3'h7: h = 7'h20;
    endcase
    return h;
  endfunction : half_period

  // bit that leaves the shift register first
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    return lsb ? sh[0] : sh[7];
  endfunction : out_bit

  // shift one received bit in, opposite end to the one leaving
  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic lsb,
                                          input logic b);
    return lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

endpackage : spi_port_pkg

// file: hdl/pin_sync.sv
// two-stage synchroniser for the four serial pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] pins_in,
  output logic [3:0] pins_sync
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  always_comb begin
    st_d.s1 = pins_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign pins_sync = st_q.s2;
endmodule : pin_sync
`default_nettype wire

// file: hdl/sck_divider.sv
// master sck half-period tick generator
// assumes run is held for a whole byte; counter restarts when run drops
`timescale 1ns/100ps
`default_nettype none
module sck_divider (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);
  import spi_port_pkg::*;

  typedef struct packed {
    logic [HALF_W-1:0] cnt;
  } div_t;

  div_t st_q;
  div_t st_d;
  logic [HALF_W-1:0] half;

  always_comb begin
    half = half_period(rate_sel);
    tick = run && (st_q.cnt == half - 7'h01);
    st_d = st_q;
    if (!run || tick) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
endmodule : sck_divider
`default_nettype wire

// file: hdl/spi_port.sv
// byte-wide serial port, master or slave, with control, status, data regs
// assumes register strobes come from ref_clk logic; pins are asynchronous
//
// Behaviour
// [R1] polarity 0: rising edge leads; polarity 1: falling edge leads
// [R2] phase 0 samples on leading edge; phase 1 samples on trailing edge
// [R3] each bit is driven on one sck edge and captured on the other
// [R4] polarity and phase together give transfer modes 0 to 3
// [R5] master divides ref_clk by 4, 16, 64 or 128 per rate bits
// [R6] double speed halves the divisors: 2, 8, 32, 64
// [R7] rate bits are ignored in slave mode; sck comes from outside
// [R8] external master keeps sck at or below a quarter of ref_clk
// [R9] transfer-complete flag, status bit 7, sets when a byte finishes
// [R10] interrupt while flag, interrupt enable and global enable all set
// [R11] master with select as input sets the flag when select goes low
// [R12] interrupt vector acknowledge clears the transfer-complete flag
// [R13] status read seeing the flag, then data access, clears it
// [R14] collision flag, status bit 6, sets on data write mid-transfer
// [R15] status read seeing collision, then data access, clears both flags
// [R16] status bits 5 to 1 read as zero
// [R17] data write loads the shift register and starts transmission
// [R18] data read returns the receive buffer, not the shift register
// [R19] sck idles high with polarity 1, low with polarity 0
// [R20] data order bit one shifts lsb first, else msb first
// [R21] select low in master mode clears master bit, falls to slave
// [R22] nothing happens on the serial side unless the port is enabled
// [R23] each transfer exchanges exactly eight bits, one per sck cycle
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module spi_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [spi_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupt side
  input wire logic global_int_en,
  input wire logic irq_ack,
  output logic irq,
  // select pin direction as configured by the port logic
  input wire logic ss_dir_input,
  // serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in
);
  import spi_port_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic dbl;
    logic spif;
    logic coll;
    logic arm_spif;
    logic arm_coll;
    logic [7:0] shreg;
    logic [7:0] rx_sh;
    logic [7:0] rx_buf;
    logic [1:0] samp_p;
    logic [1:0] fin_p;
    logic tx_bit;
    logic sck_lvl;
    logic [3:0] edge_cnt;
    xfer_state_t xfer;
    logic sck_prev;
    logic [7:0] rdata;
  } port_t;

  port_t st_q;
  port_t st_d;

  // synchronised pins
  logic [3:0] pins_sync;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pins_in({ss_n_in, miso_in, mosi_in, sck_in}),
    .pins_sync(pins_sync)
  );

  assign sck_s = pins_sync[0];
  assign mosi_s = pins_sync[1];
  assign miso_s = pins_sync[2];
  assign ss_n_s = pins_sync[3];

  // control decode
  logic en;
  logic master;
  logic clock_polarity;
  logic clock_phase;
  logic lsb_first;
  logic running;
  logic [2:0] rate_sel;
  logic tick;

  assign en = st_q.ctrl[CTRL_EN];
  assign master = st_q.ctrl[CTRL_MSTR];
  assign clock_polarity = st_q.ctrl[CTRL_CLOCK_POLARITY];
  assign clock_phase = st_q.ctrl[CTRL_CLOCK_PHASE];
  assign lsb_first = st_q.ctrl[CTRL_ORDER]; // R20
  assign running = (st_q.xfer == ST_RUN);
  assign rate_sel = {st_q.dbl, st_q.ctrl[CTRL_RATE_HI],
                     st_q.ctrl[CTRL_RATE_LO]}; // R5 R6

  // divider only runs for a master transfer, so slave ignores rate bits
  sck_divider u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run(running && master && en), // R7
    .rate_sel(rate_sel),
    .tick(tick)
  );

  // bus decode
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic data_access;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_stat = reg_wr && (reg_addr == ADDR_STAT);
  assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
  assign rd_stat = reg_rd && (reg_addr == ADDR_STAT);
  assign rd_data = reg_rd && (reg_addr == ADDR_DATA);
  assign data_access = wr_data || rd_data;

  // serial events
  logic ss_low;
  logic mode_fault;
  logic slave_sel;
  logic sck_edge;
  logic edge_ev;
  logic sample_ev;
  logic setup_ev;
  logic in_bit;
  logic [7:0] shifted;
  logic done;
  logic collide;
  logic m_samp;
  logic rx_in;
  logic [7:0] rx_next;
  logic fin_ev;

  assign ss_low = !ss_n_s;
  assign mode_fault = en && master && ss_dir_input && ss_low; // R11 R21
  assign slave_sel = en && !master && ss_low;
  assign sck_edge = sck_s ^ st_q.sck_prev;
  // every sck edge is a half-edge; even index is the leading one
  assign edge_ev = (master && running && tick)
                 || (slave_sel && sck_edge); // R22
  // phase 0 samples on even (leading), phase 1 on odd (trailing)
  assign sample_ev = edge_ev && (st_q.edge_cnt[0] == clock_phase); // R2 R4
  assign setup_ev = edge_ev && (st_q.edge_cnt[0] != clock_phase); // R3
  assign in_bit = master ? miso_s : mosi_s;
  assign shifted = shift_in(st_q.shreg, lsb_first, in_bit); // R20
  assign collide = wr_data && running; // R14
  assign done = edge_ev && (st_q.edge_cnt == EDGE_LAST); // R23

  // the master's miso needs two cycles to cross the synchroniser, so its
  // sample point is replayed two cycles later against the synced level
  assign m_samp = master && sample_ev; // R2
  assign rx_in = master ? miso_s : mosi_s;
  assign rx_next = shift_in(st_q.rx_sh, lsb_first, rx_in); // R20
  // master byte ends once the last delayed sample has landed
  assign fin_ev = st_q.fin_p[1] && master; // R9

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.sck_prev = sck_s;
    st_d.samp_p = {st_q.samp_p[0], m_samp};
    st_d.fin_p = {st_q.fin_p[0], master && done};

    // delayed master capture
    if (st_q.samp_p[1]) begin
      st_d.rx_sh = rx_next; // R2 R23
    end

    // control and status writes
    if (wr_ctrl) begin
      st_d.ctrl = reg_wdata;
    end
    if (wr_stat) begin
      st_d.dbl = reg_wdata[STAT_DBL]; // R6
    end

    // an idle slave keeps its first outgoing bit on the line
    if (!running && !master) begin
      st_d.tx_bit = out_bit(st_q.shreg, lsb_first);
    end

    // data write: load and, as master, start
    if (wr_data && !running) begin
      st_d.shreg = reg_wdata; // R17
      st_d.tx_bit = out_bit(reg_wdata, lsb_first); // R20
      if (en && master) begin
        st_d.xfer = ST_RUN; // R17
        st_d.edge_cnt = '0;
        st_d.sck_lvl = 1'b0;
      end
    end

    // one sck half-edge
    if (edge_ev) begin
      st_d.xfer = ST_RUN;
      st_d.sck_lvl = !st_q.sck_lvl; // R1
      st_d.edge_cnt = 4'(st_q.edge_cnt + 4'h1);
      if (sample_ev) begin
        st_d.shreg = shifted; // R2 R23
      end
      if (sample_ev && !master) begin
        st_d.rx_sh = rx_next; // R2 R23
      end
      if (setup_ev) begin
        st_d.tx_bit = out_bit(st_q.shreg, lsb_first); // R3
      end
      if (done) begin
        st_d.xfer = ST_IDLE;
        st_d.edge_cnt = '0;
        st_d.sck_lvl = 1'b0; // R19
        if (!master) begin
          st_d.rx_buf = sample_ev ? rx_next : st_q.rx_sh; // R18 R23
        end
      end
    end
    if (fin_ev) begin
      st_d.rx_buf = st_q.samp_p[1] ? rx_next : st_q.rx_sh; // R18 R23
    end

    // slave deselect drops a partial byte and resyncs the bit count
    if (!master && !ss_low && running) begin
      st_d.xfer = ST_IDLE;
      st_d.edge_cnt = '0;
      st_d.sck_lvl = 1'b0;
    end

    // disabled port stops everything
    if (!en) begin
      st_d.xfer = ST_IDLE; // R22
      st_d.edge_cnt = '0;
      st_d.sck_lvl = 1'b0;
      st_d.samp_p = '0;
      st_d.fin_p = '0;
    end

    // another master pulled select low: back off to slave
    if (mode_fault) begin
      st_d.ctrl[CTRL_MSTR] = 1'b0; // R21
      st_d.xfer = ST_IDLE;
      st_d.edge_cnt = '0;
      st_d.sck_lvl = 1'b0;
      st_d.samp_p = '0;
      st_d.fin_p = '0;
    end

    // flag clearing sequences
    if (rd_stat) begin
      st_d.arm_spif = st_q.spif; // R13
      st_d.arm_coll = st_q.coll; // R15
    end
    if (data_access) begin
      if (st_q.arm_spif) begin
        st_d.spif = 1'b0; // R13
      end
      if (st_q.arm_coll) begin
        st_d.spif = 1'b0; // R15
        st_d.coll = 1'b0; // R15
      end
      st_d.arm_spif = 1'b0;
      st_d.arm_coll = 1'b0;
    end
    if (irq_ack) begin
      st_d.spif = 1'b0; // R12
    end

    // a new event outranks a clear in the same cycle
    if ((done && !master) || fin_ev || mode_fault) begin
      st_d.spif = 1'b1; // R9 R11
    end
    if (collide) begin
      st_d.coll = 1'b1; // R14
    end

    // read data stand in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: st_d.rdata = st_q.ctrl;
        ADDR_STAT: st_d.rdata = {st_q.spif, st_q.coll, 5'h00,
                                 st_q.dbl}; // R16
        ADDR_DATA: st_d.rdata = st_q.rx_buf; // R18
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q.ctrl <= CTRL_RST;
      st_q.dbl <= 1'b0;
      st_q.spif <= 1'b0;
      st_q.coll <= 1'b0;
      st_q.arm_spif <= 1'b0;
      st_q.arm_coll <= 1'b0;
      st_q.shreg <= DATA_RST;
      st_q.rx_sh <= DATA_RST;
      st_q.rx_buf <= DATA_RST;
      st_q.samp_p <= 2'h0;
      st_q.fin_p <= 2'h0;
      st_q.tx_bit <= 1'b0;
      st_q.sck_lvl <= 1'b0;
      st_q.edge_cnt <= '0;
      st_q.xfer <= ST_IDLE;
      st_q.sck_prev <= 1'b0;
      st_q.rdata <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // outputs
  assign reg_rdata = st_q.rdata;
  assign irq = st_q.ctrl[CTRL_IE] && st_q.spif && global_int_en; // R10
  assign sck_out = clock_polarity ^ st_q.sck_lvl; // R1 R19
  assign sck_oe = en && master;
  assign mosi_out = st_q.tx_bit;
  assign mosi_oe = en && master;
  assign miso_out = st_q.tx_bit;
  assign miso_oe = slave_sel;

endmodule : spi_port
`default_nettype wire

// file: sim/spi_port_monitor.sv
// assertion checker on the serial port's top-level ports
// bound to every spi_port instance; one ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module spi_port_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [spi_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic global_int_en,
  input wire logic irq_ack,
  input wire logic irq,
  input wire logic ss_dir_input,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_in
);
  import spi_port_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence stat_read_s;
    reg_rd && reg_addr == ADDR_STAT ##1 1'b1;
  endsequence
  sequence mode_fault_s;
    (sck_oe && ss_dir_input && !ss_n_in) [*2];
  endsequence
  sequence deselected_s;
    ss_n_in [*4];
  endsequence
  chk_irq_gate: assert property (irq |-> global_int_en)
    else $error("irq without global enable");
  chk_ack_clear: assert property (irq_ack |=> !irq)
    else $error("irq survives acknowledge");
  chk_resv_zero: assert property (stat_read_s |-> reg_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_oe_pair: assert property (sck_oe == mosi_oe)
    else $error("clock and data enables differ");
  chk_oe_excl: assert property (!(mosi_oe && miso_oe))
    else $error("master and slave outputs both on");
  chk_mode_fault: assert property (mode_fault_s |-> ##[0:3] !sck_oe)
    else $error("master kept after select low");
  chk_slave_idle: assert property (deselected_s |-> !miso_oe)
    else $error("slave output while deselected");
endmodule : spi_port_monitor
bind spi_port spi_port_monitor u_mon (.ref_clk, .sys_rst, .reg_addr,
  .reg_rd, .reg_rdata, .global_int_en, .irq_ack, .irq, .ss_dir_input,
  .sck_oe, .mosi_oe, .miso_oe, .ss_n_in);
`default_nettype wire

// file: sim/spi_slave_model.sv
// behavioural serial slave facing the port in master mode
// format and select come from the bench; miso shows the inverse of its last bit when deselected
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  int ns;
  int nr;
  function automatic int idx(input int k);
    return lsb ? k : 7 - k;
  endfunction : idx
  initial begin
    miso = 1'b0;
    rx = 8'h00;
  end
  always @(negedge sel_n) begin
    ns = 0;
    nr = 0;
    if (!clock_phase) begin
      miso = tx[idx(0)];
      ns = 1;
    end
  end
  // released line shows the inverse of the last bit
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n) begin
      if (sck ^ clock_polarity ^ clock_phase) begin
        if (nr < 8) rx[idx(nr)] = mosi;
        nr++;
      end else if (ns < 8) begin
        miso = tx[idx(ns)];
        ns++;
      end
    end
  end
endmodule : spi_slave_model
`default_nettype wire

// file: sim/tb.sv
// self-checking bench: register port, master and slave transfers
// spi_slave_model stands on the serial side in master mode
`timescale 1ns/100ps
`default_nettype none
module tb;
  import spi_port_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, global_int_en, irq_ack;
  logic ss_dir_input, ss_n_in, m_sck, m_mosi, sel_n, clock_polarity, clock_phase, lsb;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, tx, dat, d, got;
  logic [31:0] sd;
  wire logic [7:0] reg_rdata, mdl_rx;
  wire logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  wire logic mdl_miso;
  wire logic sck_w = sck_oe ? sck_out : m_sck;
  wire logic mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire logic miso_w = miso_oe ? miso_out : mdl_miso;
  int n_fail = 0;
  int compares = 0;
  int n, dv;
  int dvt[4] = '{4, 16, 64, 128};

  spi_port u_dut (.ref_clk, .sys_rst, .clk_en(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .global_int_en, .irq_ack, .irq,
    .ss_dir_input, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w),
    .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in);
  spi_slave_model u_slv (.sck(sck_w), .mosi(mosi_w), .sel_n, .clock_polarity, .clock_phase,
    .lsb, .tx, .miso(mdl_miso), .rx(mdl_rx));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got_v, exp_v);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test;
  end
  initial begin
    {reg_wr, reg_rd, irq_ack, ss_dir_input, m_sck, m_mosi} = '0;
    {clock_polarity, clock_phase, lsb, reg_addr, reg_wdata, tx} = '0;
    {sys_rst, ss_n_in, sel_n, global_int_en} = '1;
    sd = 32'h146AA;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], d);
      chk(d, 8'h00);
    end
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, d);
    chk(d, 8'h01);
    wr(2'h3, 8'hA5);
    rd(2'h3, d);
    chk(d, 8'h00);
    // every mode, rate code and speed; odd passes collide
    for (int i = 0; i < 8; i++) begin
      sd = lfsr_next(sd);
      tx = sd[7:0];
      dat = sd[15:8];
      lsb = sd[16];
      {clock_polarity, clock_phase} = i[1:0];
      dv = dvt[i[1:0]] >> i[2];
      wr(ADDR_CTRL, {2'b11, lsb, 1'b1, i[1:0], i[1:0]});
      wr(ADDR_STAT, {7'h00, i[2]});
      chk({7'h00, sck_w}, {7'h00, clock_polarity});
      sel_n <= 1'b0;
      wr(ADDR_DATA, dat);
      n = 0;
      if (i[0]) begin
        wr(ADDR_DATA, ~dat);
        n = 2;
      end
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge ref_clk);
        #1 n++;
      end
      chk({7'h00, n >= 8 * dv && n <= 8 * dv + 6}, 8'h01);
      chk(mdl_rx, dat);
      @(posedge ref_clk);
      if (i == 7) irq_ack <= 1'b1;
      else global_int_en <= 1'b0;
      #1 chk({7'h00, irq}, {7'h00, i == 7});
      @(posedge ref_clk);
      irq_ack <= 1'b0;
      global_int_en <= 1'b1;
      #1 chk({7'h00, irq}, {7'h00, i != 7});
      rd(ADDR_STAT, d);
      chk(d, {i != 7, i[0], 5'h00, i[2]});
      rd(ADDR_DATA, d);
      chk(d, tx);
      rd(ADDR_STAT, d);
      chk(d, {7'h00, i[2]});
      sel_n <= 1'b1;
    end
    wr(ADDR_STAT, 8'h00);
    ss_dir_input <= 1'b1;
    wr(ADDR_CTRL, 8'h53);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ss_n_in <= 1'b1;
    ss_dir_input <= 1'b0;
    rd(ADDR_CTRL, d);
    chk(d, 8'h43);
    rd(ADDR_STAT, d);
    chk(d, 8'h80);
    rd(ADDR_DATA, d);
    // slave byte at an eighth of the clock rate, rate bits set
    sd = lfsr_next(sd);
    tx = sd[7:0];
    dat = sd[15:8];
    wr(ADDR_CTRL, 8'hC3);
    wr(ADDR_DATA, tx);
    ss_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int b = 7; b >= 0; b--) begin
      m_mosi <= dat[b];
      repeat (4) @(posedge ref_clk);
      m_sck <= 1'b1;
      got[b] = miso_w;
      repeat (4) @(posedge ref_clk);
      m_sck <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    ss_n_in <= 1'b1;
    rd(ADDR_STAT, d);
    chk(d, 8'h80);
    rd(ADDR_DATA, d);
    chk(d, dat);
    chk(got, tx);
    end_of_test;
  end
endmodule : tb
`default_nettype wire
